// ==== core/ssp_port.sv ====
// Serial register port, SPI mode, oversampled by the core clock
`timescale 1ns/1ps
module ssp_port #(
    parameter int BURST_MAX = ssp_pkg::BURST_MAX
) (
    input  wire logic                       CORE_CLK_IN,
    input  wire logic                       RESET_IN,
    input  wire logic                       SCLK_IN,
    input  wire logic                       CS_N_IN,
    input  wire logic                       DATA_IN_PIN_IN,
    input  wire logic                       SDIO_IN,
    output logic                            SDIO_OUT,
    output logic                            SDIO_OE_OUT,
    input  wire ssp_pkg::ssp_cfg_t          CFG_IN,
    output ssp_pkg::ssp_req_t               REQ_OUT,
    output logic                            BUS_HOLD_OUT,
    input  wire logic                       BUS_GRANT_IN,
    input  wire logic [7:0]                 RDATA_IN,
    output logic [31:0]                     PAGE_OUT
);
    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [ssp_pkg::SYNC_STAGES-1:0] sclk_sync;
    logic [ssp_pkg::SYNC_STAGES-1:0] cs_sync;
    logic [ssp_pkg::SYNC_STAGES-1:0] din_sync;
    logic [ssp_pkg::SYNC_STAGES-1:0] dio_sync;
    logic                            sclk_prev;

    always_ff @(posedge CORE_CLK_IN) begin
        sclk_sync <= {sclk_sync[0], SCLK_IN};
        cs_sync   <= {cs_sync[0], CS_N_IN};
        din_sync  <= {din_sync[0], DATA_IN_PIN_IN};
        dio_sync  <= {dio_sync[0], SDIO_IN};
        sclk_prev <= sclk_sync[1];
    end

    wire sclk_s    = sclk_sync[1];
    wire cs_high   = cs_sync[1];
    wire rise      = sclk_s & ~sclk_prev;
    wire fall      = ~sclk_s & sclk_prev;
    wire samp_edge = (CFG_IN.sample_fall ? fall : rise) & ~cs_high;
    wire lnch_edge = (CFG_IN.sample_fall ? rise : fall) & ~cs_high;
    wire in_bit    = CFG_IN.three_wire ? dio_sync[1] : din_sync[1];

    ////////////////////////////////////////////////////////////////////////
    // Frame state
    ssp_pkg::ssp_state_t     state;
    ssp_pkg::ssp_state_t     next_state;
    logic [2:0]              bit_cnt;
    logic [7:0]              shift_in;
    logic                    rd_flag;
    logic [14:0]             ofs;
    logic [4:0]              byte_cnt;
    logic [31:0]             page;
    logic [7:0]              shift_out;
    logic                    out_late;
    logic                    driving;

    wire [7:0] byte_now  = {shift_in[6:0], in_bit};
    wire       byte_done = samp_edge && (bit_cnt == 3'h7);
    wire       rw_bit    = byte_now[7];
    wire       last_addr = CFG_IN.two_byte ? (state == ssp_pkg::SSP_ADDR_LO) : (state == ssp_pkg::SSP_ADDR_HI);

    // Full register address from page and offset
    wire [15:0] addr_1b  = {page[15:7], ofs[6:0]};
    wire [15:0] addr_2b  = {page[15], ofs};
    wire [15:0] addr_now = CFG_IN.two_byte ? addr_2b : addr_1b;

    // Page register hit and byte lane within it
    wire        page_hit_1b = !CFG_IN.two_byte && (ofs[6:0] >= ssp_pkg::PAGE_OFS_1B);
    wire        page_hit_2b = CFG_IN.two_byte && (ofs >= ssp_pkg::PAGE_OFS_2B);
    wire [1:0]  page_lane   = CFG_IN.two_byte ? 2'(ofs - ssp_pkg::PAGE_OFS_2B + 15'h0001)
                                              : 2'(ofs[6:0] - ssp_pkg::PAGE_OFS_1B);
    wire        page_hit    = page_hit_1b | page_hit_2b;

    always_comb begin
        next_state = state;
        case (state)
            ssp_pkg::SSP_ADDR_HI: next_state = last_addr ? ssp_pkg::SSP_DATA : ssp_pkg::SSP_ADDR_LO;
            ssp_pkg::SSP_ADDR_LO: next_state = ssp_pkg::SSP_DATA;
            ssp_pkg::SSP_DATA:    next_state = ssp_pkg::SSP_DATA;
            default:              next_state = ssp_pkg::SSP_ADDR_HI;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN || cs_high) begin
            state    <= ssp_pkg::SSP_ADDR_HI;
            bit_cnt  <= 3'h0;
            shift_in <= 8'h00;
            byte_cnt <= 5'h00;
        end else if (samp_edge) begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= byte_now;
            if (byte_done) begin
                state <= next_state;
                if (state == ssp_pkg::SSP_DATA && byte_cnt != 5'h1F) begin
                    byte_cnt <= byte_cnt + 5'h01;
                end
            end
        end
    end

    // Offset and direction capture, pointer advance
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            rd_flag <= 1'b0;
            ofs     <= 15'h0000;
        end else if (byte_done) begin
            case (state)
                ssp_pkg::SSP_ADDR_HI: begin
                    rd_flag <= byte_now[7];
                    ofs     <= {byte_now[6:0], 8'h00};
                    if (!CFG_IN.two_byte) begin
                        ofs <= {8'h00, byte_now[6:0]};
                    end
                end
                ssp_pkg::SSP_ADDR_LO: ofs <= {ofs[14:8], byte_now};
                ssp_pkg::SSP_DATA:    ofs <= ofs + 15'h0001;
                default:              ofs <= ofs;
            endcase
        end
    end

    // Page register, written a byte at a time in the burst
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            page <= ssp_pkg::PAGE_RESET;
        end else if (byte_done && state == ssp_pkg::SSP_DATA && !rd_flag && page_hit) begin
            page[8*page_lane +: 8] <= byte_now;
        end
    end
    assign PAGE_OUT = page;

    ////////////////////////////////////////////////////////////////////////
    // Shared bus request: held from first data byte to chip select high or BURST_MAX bytes
    wire data_phase = (state == ssp_pkg::SSP_DATA);
    logic rd_fetch;
    // Fetch after the address, then again for every byte read
    wire rd_start = byte_done && last_addr && !data_phase && (CFG_IN.two_byte ? rd_flag : rw_bit);
    wire rd_next  = byte_done && data_phase && rd_flag;
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN) begin
            REQ_OUT      <= '0;
            BUS_HOLD_OUT <= 1'b0;
            rd_fetch     <= 1'b0;
        end else begin
            REQ_OUT.wr   <= byte_done && data_phase && !rd_flag && !page_hit;
            REQ_OUT.rd   <= rd_fetch;
            REQ_OUT.addr <= addr_now;
            REQ_OUT.wdata <= byte_now;
            // Atomic hold covers at most BURST_MAX bytes
            BUS_HOLD_OUT <= !cs_high && data_phase && (byte_cnt < 5'(BURST_MAX));
            rd_fetch     <= rd_start || rd_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data shifter
    // Byte lane of the page register
    function automatic logic [7:0] lane_byte(input logic [31:0] word, input logic [1:0] lane);
        lane_byte = word[8*lane +: 8];
    endfunction

    wire [7:0] rd_src  = page_hit ? lane_byte(page, page_lane) : RDATA_IN;
    wire       out_msb = shift_out[7];
    always_ff @(posedge CORE_CLK_IN) begin
        if (RESET_IN || cs_high) begin
            shift_out <= 8'h00;
            out_late  <= 1'b0;
            driving   <= 1'b0;
        end else begin
            if (REQ_OUT.rd) begin
                shift_out <= rd_src;
                driving   <= 1'b1;
            end else if (samp_edge && data_phase) begin
                shift_out <= {shift_out[6:0], 1'b0};
            end
            // Taken on the launch edge, so it stands over the next sample edge
            if (lnch_edge) begin
                out_late <= out_msb;
            end
        end
    end
    // Next read byte fetched at the pointer after each byte
    assign SDIO_OUT    = CFG_IN.read_delay ? out_late : (data_phase ? shift_out[7] : 1'b0);
    assign SDIO_OE_OUT = driving && !cs_high;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    // Steps of a transfer
    sequence s_read_fetch;
        rd_fetch ##1 (REQ_OUT.rd && !cs_high);
    endsequence
    sequence s_write_byte;
        byte_done && data_phase && !rd_flag && !page_hit;
    endsequence
    sequence s_page_byte;
        byte_done && data_phase && !rd_flag && page_hit;
    endsequence
    sequence s_addr_end;
        byte_done && state == ssp_pkg::SSP_ADDR_HI;
    endsequence

    a_cs_release: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        cs_high |=> !driving && !SDIO_OE_OUT)
        else $error("shared pin driven with select high");

    a_counter_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        cs_high |=> bit_cnt == 3'h0 && state == ssp_pkg::SSP_ADDR_HI)
        else $error("frame not abandoned");

    a_pointer_step: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        byte_done && data_phase && !cs_high |=> ofs == $past(ofs) + 15'h0001)
        else $error("pointer did not step");

    a_addr_one: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        REQ_OUT.wr && !CFG_IN.two_byte |-> REQ_OUT.addr[15:7] == page[15:7])
        else $error("page bits wrong");

    a_bit_count: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN || cs_high)
        samp_edge |=> bit_cnt == $past(bit_cnt) + 3'h1)
        else $error("bit count slip");

    a_wire_mode: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        SDIO_OE_OUT |-> data_phase && rd_flag)
        else $error("shared pin driven outside read data");

    a_read_load: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_read_fetch |=> driving && shift_out == $past(rd_src))
        else $error("read byte not loaded");

    a_fetch_pulse: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_read_fetch |=> !REQ_OUT.rd)
        else $error("read request longer than one cycle");

    a_write_pulse: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_write_byte |=> REQ_OUT.wr && REQ_OUT.wdata == $past(byte_now) && REQ_OUT.addr == $past(addr_now))
        else $error("write request wrong");

    a_write_single: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        REQ_OUT.wr |=> !REQ_OUT.wr)
        else $error("write request longer than one cycle");

    a_page_refuse: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_page_byte |=> !REQ_OUT.wr)
        else $error("page byte went to the shared bus");

    a_page_store: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_page_byte |=> lane_byte(page, $past(page_lane)) == $past(byte_now))
        else $error("page byte not stored");

    a_addr_two: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        REQ_OUT.wr && CFG_IN.two_byte |-> REQ_OUT.addr[15] == page[15])
        else $error("page bit wrong in two-byte mode");

    a_rw_capture: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        s_addr_end |=> rd_flag == $past(rw_bit))
        else $error("direction flag not taken from first bit");

    a_msb_first: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN || cs_high)
        samp_edge |=> shift_in[0] == $past(in_bit))
        else $error("input bit not shifted in");

    a_hold_burst: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        BUS_HOLD_OUT |-> $past(data_phase))
        else $error("bus held outside data phase");

    a_hold_clear: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN)
        cs_high |=> !BUS_HOLD_OUT)
        else $error("bus held after select high");

    a_late_hold: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN || cs_high)
        !lnch_edge |=> $stable(out_late))
        else $error("late read bit moved off the launch edge");

    a_walk_one: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN || cs_high)
        s_addr_end ##0 !CFG_IN.two_byte |=> data_phase)
        else $error("one-byte offset did not end address phase");

    a_walk_two: assert property (@(posedge CORE_CLK_IN) disable iff (RESET_IN || cs_high)
        s_addr_end ##0 CFG_IN.two_byte |=> state == ssp_pkg::SSP_ADDR_LO)
        else $error("two-byte offset skipped second address byte");
endmodule

// ==== core/ssp_pkg.sv ====
// Package of constants and types for the serial register port
package ssp_pkg;
    localparam logic [6:0]  PAGE_OFS_1B     = 7'h7C;    // Page register offset, one-byte mode
    localparam logic [14:0] PAGE_OFS_2B     = 15'h7FFD; // Page register offset, two-byte mode
    localparam int          PAGE_BYTES_1B   = 4;
    localparam int          PAGE_BYTES_2B   = 3;
    localparam logic [31:0] PAGE_RESET      = 32'h0000_0000;
    localparam int          PAGE_HI_1B      = 9;        // Upper bits from page register
    localparam int          OFS_BITS_1B     = 7;
    localparam int          OFS_BITS_2B     = 15;
    localparam int          ADDR_W          = 16;
    localparam int          BURST_MAX       = 16;       // Atomic burst length on the shared bus
    localparam int          SYNC_STAGES     = 2;

    typedef enum logic [1:0] {
        SSP_ADDR_HI = 2'b00,
        SSP_ADDR_LO = 2'b01,
        SSP_DATA    = 2'b10
    } ssp_state_t;

    // Settings that steer the port
    typedef struct packed {
        logic three_wire;     // 1: shared pin carries both directions
        logic two_byte;       // 1: two_byte_offset_mode
        logic sample_fall;    // 1: sample on falling edge
        logic read_delay;     // 1: add half clock to read data
    } ssp_cfg_t;

    // Request onto the shared internal register bus
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } ssp_req_t;
endpackage

// ==== dv/ssp_host_model.sv ====
// Host model: serial master that frames, clocks and shifts bytes
`timescale 1ns/1ps
module ssp_host_model (
    input  wire logic fall_in,
    input  wire logic miso_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      mosi_out
);
    localparam realtime HALF = 62.5; // 8 MHz, well under the 40 MHz limit
    logic [7:0] rx_q[$];
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // Whole bytes MSB first, R/W flag leading; nb below 8 per byte aborts
    task automatic frame(input logic [7:0] tx[$], input int nb);
        logic [7:0] rx;
        rx = 8'h00;
        rx_q.delete();
        sclk_out = fall_in; // Idle level puts the sample edge first
        #HALF cs_n_out = 1'b0;
        for (int i = 0; i < nb; i++) begin
            mosi_out = tx[i / 8][7 - i % 8];
            #HALF rx = {rx[6:0], miso_in}; // Read bit taken just before the sample edge
            sclk_out = ~sclk_out;
            #HALF sclk_out = ~sclk_out;
            if (i % 8 == 7) begin
                rx_q.push_back(rx);
            end
        end
        #HALF cs_n_out = 1'b1;
        mosi_out = ~mosi_out; // Released line must not keep its last value
        #(4 * HALF);
    endtask
endmodule

// ==== dv/ssp_port_tb.sv ====
// Self-checking bench for the serial register port
`timescale 1ns/1ps
module ssp_port_tb;
    typedef struct {logic [3:0] cfg; logic [7:0] a; logic [7:0] d; logic [15:0] addr;} ssp_row_t;
    logic              clk = 1'b0, rst = 1'b1, sdio_out, sdio_oe, hold, sclk, cs_n, mosi;
    logic [7:0]        rdata = 8'h00;
    logic [31:0]       page;
    ssp_pkg::ssp_cfg_t cfg = '0;
    ssp_pkg::ssp_req_t req;
    ssp_pkg::ssp_req_t req_q[$];
    int                errors = 0, cmp_count = 0, hold_cycles = 0;
    wire               sdio = sdio_oe ? sdio_out : mosi; // Shared pin level from both drivers
    // Page 0x2010CB80 gives upper nine address bits 0x197
    ssp_row_t rows[6] = '{'{4'h0, 8'h64, 8'h50, 16'hCBE4}, '{4'h0, 8'hA4, 8'h3A, 16'hCBA4},
                          '{4'h2, 8'h65, 8'h3C, 16'hCBE5}, '{4'h1, 8'hA4, 8'hC5, 16'hCBA4},
                          '{4'h8, 8'h01, 8'hC3, 16'hCB81}, '{4'h8, 8'h81, 8'h96, 16'hCB81}};
    ssp_port ssp_port_inst (.CORE_CLK_IN(clk), .RESET_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n),
        .DATA_IN_PIN_IN(mosi), .SDIO_IN(sdio), .SDIO_OUT(sdio_out), .SDIO_OE_OUT(sdio_oe), .CFG_IN(cfg),
        .REQ_OUT(req), .BUS_HOLD_OUT(hold), .BUS_GRANT_IN(hold), .RDATA_IN(rdata), .PAGE_OUT(page));
    ssp_host_model ssp_host_model_inst (.fall_in(cfg.sample_fall), .miso_in(sdio), .sclk_out(sclk),
        .cs_n_out(cs_n), .mosi_out(mosi));
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        if (req.wr === 1'b1 || req.rd === 1'b1) begin
            req_q.push_back(req); // A stuck pulse shows up as extra entries
        end
        if (hold === 1'b1) begin
            hold_cycles++;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("TB: %0d compares, %0d errors", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t value %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_req(input int k, input logic rd, input logic [15:0] addr, input logic [7:0] d);
        chk_val({req_q[k].wr, req_q[k].rd, req_q[k].addr}, {~rd, rd, addr});
        if (!rd) begin
            chk_val(req_q[k].wdata, d);
        end
    endtask
    task automatic run(input logic [3:0] c, input logic [7:0] tx[$], input int nb);
        @(posedge clk) cfg <= ssp_pkg::ssp_cfg_t'(c);
        req_q.delete();
        hold_cycles = 0;
        repeat (3) @(posedge clk);
        ssp_host_model_inst.frame(tx, nb);
    endtask
    initial begin
        for (int t = 0; t < 90000; t++) @(posedge clk);
        errors++; // Run did not finish in time
        give_verdict();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk_val({page, sdio_oe}, 33'h0);
        run(4'h0, '{8'h7C, 8'h80, 8'hCB, 8'h10, 8'h20}, 40);
        chk_val({page, 24'(req_q.size())}, {32'h2010CB80, 24'h0});
        $display("TB: page setup done");
        for (int i = 0; i < 6; i++) begin
            @(posedge clk) rdata <= rows[i].d;
            run(rows[i].cfg, '{rows[i].a, rows[i].a[7] ? 8'h00 : rows[i].d}, 16);
            chk_val(req_q.size(), rows[i].a[7] ? 2 : 1);
            chk_req(0, rows[i].a[7], rows[i].addr, rows[i].d);
            if (rows[i].a[7]) begin
                chk_val(ssp_host_model_inst.rx_q[1], rows[i].d);
                chk_req(1, 1'b1, rows[i].addr + 16'h0001, 8'h00);
            end
            chk_val(sdio_oe, 1'b0);
            $display("TB: row %0d done", i);
        end
        run(4'h0, '{8'h10, 8'h11, 8'h22}, 24);
        chk_req(0, 1'b0, 16'hCB90, 8'h11);
        chk_req(1, 1'b0, 16'hCB91, 8'h22);
        chk_val(hold_cycles >= 150, 1);
        $display("TB: burst done");
        run(4'h0, '{8'h20, 8'hFF}, 12);
        chk_val(req_q.size(), 0);
        run(4'h0, '{8'h30, 8'h77}, 16);
        chk_val(req_q.size(), 1);
        chk_req(0, 1'b0, 16'hCBB0, 8'h77);
        $display("TB: abort done");
        run(4'h4, '{8'h7F, 8'hFD, 8'h80, 8'h10, 8'h20}, 40);
        chk_val({page[31:8], 8'(req_q.size())}, {24'h201080, 8'h0});
        run(4'h4, '{8'h4B, 8'hE4, 8'h50}, 24);
        chk_req(0, 1'b0, 16'hCBE4, 8'h50);
        @(posedge clk) rdata <= 8'h5A;
        run(4'h4, '{8'hCB, 8'hE4, 8'h00}, 24);
        chk_req(0, 1'b1, 16'hCBE4, 8'h00);
        chk_req(1, 1'b1, 16'hCBE5, 8'h00);
        chk_val(ssp_host_model_inst.rx_q[2], 8'h5A);
        $display("TB: two-byte mode done");
        @(posedge clk) rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk_val(page, 32'h0);
        $display("TB: second reset done");
        give_verdict();
    end
endmodule
